// ===== rbam_top.sv
// Mapper top: mapper registers, load sequencer, inhibit, address out.
// Assumes the core presents opcode fetch strobes and register values.
`timescale 1ns/1ps
`include "rbam_params.svh"
////////////////////////////////////////////////////////////////////////
// Contract
// (RQ1) Eight equal blocks, two four-block regions
// (RQ2) Unmapped block passes address unchanged
// (RQ3) Mapped block adds its region offset
// (RQ4) Low eight bits never translated
// (RQ5) Mapped output low on remapped access
// (RQ6) Load op copies A X Y Z
// (RQ7) Interrupts inhibited until next no-op
// (RQ8) Software arranges offset and enable bits
// (RQ9) Zero offset gives same address
// (RQ10) Twelve-bit add, carry discarded
// (RQ11) Reset clears enables and offsets
module rbam_top
   import rbam_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic op_fetch,
   input wire rbam_byte_t opcode,
   input wire rbam_byte_t reg_a,
   input wire rbam_byte_t reg_x,
   input wire rbam_byte_t reg_y,
   input wire rbam_byte_t reg_z,
   input wire logic addr_valid,
   input wire logic [15:0] laddr,
   output rbam_paddr_t paddr,
   output logic mapped_n,
   output logic irq_inhibit,
   output logic map_busy
);
   rbam_byte_t lower_offset_low;
   rbam_byte_t lower_enable_offset_high;
   rbam_byte_t upper_offset_low;
   rbam_byte_t upper_enable_offset_high;
   rbam_state_t state;
   rbam_state_t next_state;
   logic [2:0] cyc;
   logic [2:0] next_cyc;
   rbam_byte_t a_hold;
   rbam_byte_t x_hold;
   rbam_byte_t y_hold;
   rbam_byte_t z_hold;
   rbam_paddr_t comb_paddr;
   logic comb_mapped;
   ////////////////////////////////////////////////////////////////////
   wire logic is_map = op_fetch && opcode == `RBAM_OP_MAP;
   wire logic is_nop = op_fetch && opcode == `RBAM_OP_NOP;
   wire logic last_cyc = state == RBAM_LOAD && cyc == `RBAM_MAP_CYCLES - 3'h1;
   wire logic take = state == RBAM_IDLE && is_map;
   wire logic release_nop = state == RBAM_IDLE && is_nop;
   wire logic next_busy = take || (state == RBAM_LOAD && !last_cyc);
   wire rbam_off_t lower_off = {lower_enable_offset_high[3:0],
                                lower_offset_low}; // RQ8
   wire rbam_off_t upper_off = {upper_enable_offset_high[3:0],
                                upper_offset_low}; // RQ8
   wire logic [7:0] enables = {upper_enable_offset_high[7:4],
                               lower_enable_offset_high[7:4]}; // RQ8
   rbam_xlate u_xlate (
      .laddr(laddr),
      .lower_off(lower_off),
      .upper_off(upper_off),
      .block_remap_enable(enables),
      .paddr(comb_paddr),
      .mapped(comb_mapped)
   );
   ////////////////////////////////////////////////////////////////////
   // Opcodes fetched while loading are refused by staying in LOAD
   always_comb begin
      next_state = state;
      next_cyc = cyc;
      unique case (state)
         RBAM_IDLE: begin
            if (is_map) begin
               next_state = RBAM_LOAD; // RQ6
               next_cyc = 3'h1;
            end
         end
         RBAM_LOAD: begin
            if (last_cyc) begin
               next_state = RBAM_IDLE;
               next_cyc = 3'h0;
            end else begin
               next_cyc = cyc + 3'h1;
            end
         end
         default: begin
            next_state = RBAM_IDLE;
            next_cyc = 3'h0;
         end
      endcase
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= RBAM_IDLE;
         cyc <= 3'h0;
      end else begin
         state <= next_state;
         cyc <= next_cyc;
      end
   end
   // Snapshot at the take edge; the map registers change only at the
   // last cycle, so the new map steers accesses after the instruction
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         a_hold <= `RBAM_RST_BYTE;
         x_hold <= `RBAM_RST_BYTE;
         y_hold <= `RBAM_RST_BYTE;
         z_hold <= `RBAM_RST_BYTE;
      end else if (take) begin
         a_hold <= reg_a; // RQ6
         x_hold <= reg_x; // RQ6
         y_hold <= reg_y; // RQ6
         z_hold <= reg_z; // RQ6
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lower_offset_low <= `RBAM_RST_BYTE; // RQ11
         lower_enable_offset_high <= `RBAM_RST_BYTE; // RQ11
         upper_offset_low <= `RBAM_RST_BYTE; // RQ11
         upper_enable_offset_high <= `RBAM_RST_BYTE; // RQ11
      end else if (last_cyc) begin
         lower_offset_low <= a_hold; // RQ6
         lower_enable_offset_high <= x_hold; // RQ6
         upper_offset_low <= y_hold; // RQ6
         upper_enable_offset_high <= z_hold; // RQ6
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_inhibit <= 1'b0;
      end else if (take) begin
         irq_inhibit <= 1'b1; // RQ7
      end else if (release_nop) begin
         irq_inhibit <= 1'b0; // RQ7
      end
   end
   // Registered output adds one cycle of latency to the bus address
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         paddr <= 20'h00000;
         mapped_n <= 1'b1;
         map_busy <= 1'b0;
      end else begin
         paddr <= comb_paddr; // RQ2 RQ3
         mapped_n <= !(comb_mapped && addr_valid); // RQ5
         map_busy <= next_busy; // RQ6
      end
   end
   ////////////////////////////////////////////////////////////////////
   // The first edge after reset has no registered access behind it
   AST_LOW_BITS: assert property (@(posedge clock) disable iff (rst) // RQ4
      !$past(rst) |-> paddr[7:0] == $past(laddr[7:0]))
      else $error("low address bits altered");
   AST_UNMAPPED: assert property (@(posedge clock) disable iff (rst) // RQ2
      (mapped_n && !$past(rst)) |->
         paddr == {4'h0, $past(laddr)} || !$past(addr_valid))
      else $error("unmapped address changed");
   AST_MAPPED_ADD: assert property (@(posedge clock) disable iff (rst) // RQ3
      !mapped_n |-> paddr[19:8] == 12'({4'h0, $past(laddr[15:8])} +
         ($past(laddr[15]) ? $past(upper_off) : $past(lower_off))))
      else $error("mapped address wrong");
   AST_FLAG: assert property (@(posedge clock) disable iff (rst) // RQ5
      $past(addr_valid) |-> mapped_n == !$past(enables[laddr[15:13]]))
      else $error("mapped flag wrong");
   AST_LOAD4: assert property (@(posedge clock) disable iff (rst) // RQ6
      take |-> ##4 lower_offset_low == $past(reg_a, 4))
      else $error("load not done in four cycles");
   AST_LOAD_Z: assert property (@(posedge clock) disable iff (rst) // RQ6
      take |-> ##4
         upper_enable_offset_high == $past(reg_z, 4))
      else $error("upper enables not loaded");
   AST_INHIBIT: assert property (@(posedge clock) disable iff (rst) // RQ7
      (state == RBAM_IDLE && is_map) |=> irq_inhibit)
      else $error("inhibit not set");
   AST_RELEASE: assert property (@(posedge clock) disable iff (rst) // RQ7
      (irq_inhibit && !is_nop) |=> irq_inhibit)
      else $error("inhibit dropped without no-op");
   AST_ZERO_OFF: assert property (@(posedge clock) disable iff (rst) // RQ9
      (lower_off == 12'h000 && upper_off == 12'h000) |=>
         paddr == {4'h0, $past(laddr)})
      else $error("zero offset changed address");
   ////////////////////////////////////////////////////////////////////
   AST_LOAD_X: assert property (@(posedge clock) disable iff (rst) // RQ6
      take |-> ##4 lower_enable_offset_high == $past(reg_x, 4))
      else $error("lower enables not loaded");
   AST_LOAD_Y: assert property (@(posedge clock) disable iff (rst) // RQ6
      take |-> ##4 upper_offset_low == $past(reg_y, 4))
      else $error("upper offset not loaded");
   AST_CLEAR: assert property (@(posedge clock) disable iff (rst) // RQ7
      release_nop |=> !irq_inhibit)
      else $error("no-op did not release inhibit");
   AST_INH_RISE: assert property (@(posedge clock) disable iff (rst) // RQ7
      (!irq_inhibit && !take) |=> !irq_inhibit)
      else $error("inhibit rose without a load");
   AST_BUSY_IRQ: assert property (@(posedge clock) disable iff (rst) // RQ7
      map_busy |-> irq_inhibit)
      else $error("inhibit low during a load");
   AST_BUSY: assert property (@(posedge clock) disable iff (rst) // RQ6
      take |=> map_busy [*3] ##1 !map_busy)
      else $error("busy length wrong");
   AST_STAY_LOAD: assert property (@(posedge clock) disable iff (rst) // RQ6
      (state == RBAM_LOAD && !last_cyc) |=> state == RBAM_LOAD)
      else $error("load sequence cut short");
   AST_IDLE_CYC: assert property (@(posedge clock) disable iff (rst) // RQ6
      state == RBAM_IDLE |-> cyc == 3'h0)
      else $error("cycle count left over in idle");
   AST_SNAPSHOT: assert property (@(posedge clock) disable iff (rst) // RQ6
      state == RBAM_LOAD |=> $stable(a_hold) && $stable(z_hold))
      else $error("refused load overwrote snapshot");
   AST_MAP_HOLD: assert property (@(posedge clock) disable iff (rst) // RQ6
      !last_cyc |=> $stable(lower_offset_low) && $stable(upper_offset_low)
         && $stable(lower_enable_offset_high)
         && $stable(upper_enable_offset_high))
      else $error("map registers changed outside a load");
   AST_RESET_MAP: assert property (@(posedge clock) disable iff (rst) // RQ11
      $past(rst) |-> lower_off == 12'h000 && upper_off == 12'h000
         && enables == 8'h00 && mapped_n && !irq_inhibit && !map_busy)
      else $error("reset left the map loaded");
endmodule

// ===== rbam_params.svh
// Constants for the region/block address mapper.
// Assumes inclusion by the mapper package and modules only.
`ifndef RBAM_PARAMS_SVH
`define RBAM_PARAMS_SVH
`define RBAM_OP_MAP 8'h5c
`define RBAM_OP_NOP 8'hea
`define RBAM_MAP_CYCLES 3'h4
`define RBAM_BLK_MSB 15
`define RBAM_BLK_LSB 13
`define RBAM_PAGE_BITS 8
`define RBAM_EN_LSB 4
`define RBAM_OFFH_MSB 3
`define RBAM_UPPER_BLK 4
`define RBAM_RST_BYTE 8'h00
`endif

// ===== rbam_pkg.sv
// Types shared by the mapper modules.
// Assumes rbam_params.svh is on the include path.
package rbam_pkg;
   typedef logic [7:0] rbam_byte_t;
   typedef logic [11:0] rbam_off_t;
   typedef logic [19:0] rbam_paddr_t;
   typedef enum logic [1:0] {RBAM_IDLE, RBAM_LOAD} rbam_state_t;
endpackage

// ===== rbam_xlate.sv
// Translation path: block select, offset add, mapped flag.
// Assumes register values are stable on the same clock.
`timescale 1ns/1ps
`include "rbam_params.svh"
module rbam_xlate
   import rbam_pkg::*;
(
   input wire logic [15:0] laddr,
   input wire rbam_off_t lower_off,
   input wire rbam_off_t upper_off,
   input wire logic [7:0] block_remap_enable,
   output rbam_paddr_t paddr,
   output logic mapped
);
   wire logic [2:0] blk = laddr[`RBAM_BLK_MSB:`RBAM_BLK_LSB]; // RQ1
   wire logic in_upper = blk[2]; // RQ1
   wire logic blk_en = block_remap_enable[blk];
   wire rbam_off_t sel_off = in_upper ? upper_off : lower_off; // RQ3
   // Carry out of bit 19 dropped by the 12-bit width
   wire logic [11:0] high_sum = 12'({4'h0, laddr[15:8]} + sel_off); // RQ10
   assign mapped = blk_en; // RQ5
   assign paddr = blk_en ? {high_sum, laddr[7:0]} // RQ3 RQ4 RQ9
                         : {4'h0, laddr}; // RQ2
endmodule

// ===== rbam_decode.sv
// Partner model: external decode behind the mapper address outputs.
// Assumes paddr and mapped_n come straight from the mapper top.
`timescale 1ns/1ps
module rbam_decode
   import rbam_pkg::*;
(
   input wire rbam_paddr_t paddr,
   input wire logic mapped_n,
   output logic io_sel
);
   // I/O stays at fixed addresses, so only untranslated hits select it
   assign io_sel = mapped_n & (paddr[15:12] == 4'hd);
endmodule

// ===== tb.sv
// Self-checking bench for the mapper top with random and corner loads.
// Assumes the mapper package is compiled first.
`timescale 1ns/1ps
module tb;
   import rbam_pkg::*;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic op_fetch = 1'h0;
   logic addr_valid = 1'h0;
   rbam_byte_t opcode = 8'h00;
   rbam_byte_t reg_a = 8'h00, reg_x = 8'h00, reg_y = 8'h00, reg_z = 8'h00;
   logic [15:0] laddr = 16'h0000;
   rbam_paddr_t paddr;
   logic mapped_n, irq_inhibit, map_busy, io_sel;
   rbam_byte_t m [4];
   int fail_count = 0;
   int checks = 0;
   int seed = 32'ha6c2;
   always #4 clock = ~clock;
   rbam_top DUT (.clock(clock), .rst(rst), .op_fetch(op_fetch),
      .opcode(opcode), .reg_a(reg_a), .reg_x(reg_x), .reg_y(reg_y),
      .reg_z(reg_z), .addr_valid(addr_valid), .laddr(laddr),
      .paddr(paddr), .mapped_n(mapped_n), .irq_inhibit(irq_inhibit),
      .map_busy(map_busy));
   rbam_decode PM (.paddr(paddr), .mapped_n(mapped_n), .io_sel(io_sel));
   ////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Twelve-bit sum in a concatenation drops the carry by width
   function automatic logic [20:0] xl(input logic [15:0] l);
      logic [2:0] b;
      logic en;
      logic [11:0] o;
      b = l[15:13];
      en = b[2] ? m[3][4 + b[1:0]] : m[1][4 + b[1:0]];
      o = b[2] ? {m[3][3:0], m[2]} : {m[1][3:0], m[0]};
      xl = en ? {1'h0, o + {4'h0, l[15:8]}, l[7:0]} : {1'h1, 4'h0, l};
   endfunction
   task automatic access(input logic [15:0] l, input logic v);
      logic [20:0] e;
      logic io_e;
      @(negedge clock);
      laddr = l;
      addr_valid = v;
      @(negedge clock);
      e = xl(l);
      chk(paddr, e[19:0]);
      chk({19'h0, mapped_n}, {19'h0, e[20] | ~v});
      // I/O decode only answers untranslated hits at its fixed page
      io_e = (e[20] | ~v) & (e[15:12] == 4'hd);
      chk({19'h0, io_sel}, {19'h0, io_e});
   endtask
   task automatic op(input rbam_byte_t c);
      @(negedge clock);
      op_fetch = 1'h1;
      opcode = c;
      @(negedge clock);
      op_fetch = 1'h0;
   endtask
   task automatic load(input logic [31:0] w);
      int n;
      {reg_z, reg_y, reg_x, reg_a} = w;
      op(8'h5c);
      chk({18'h0, irq_inhibit, map_busy}, 20'h3);
      // A second load while busy must be ignored, values included
      reg_a = ~w[7:0];
      op(8'h5c);
      // Busy stands three cycles after the take; two passed in the op
      n = 2;
      while (map_busy === 1'h1 && n < 8) begin
         @(negedge clock);
         n++;
      end
      chk(n[19:0], 20'h3);
      if (n == 8) end_sim;
      {m[3], m[2], m[1], m[0]} = w;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      int i;
      logic [31:0] w;
      repeat (8) @(negedge clock);
      rst = 1'h0;
      for (i = 0; i < 4; i++) m[i] = 8'h00;
      access(16'hfedc, 1'h1);
      load(32'hf000f000);
      access(16'h1234, 1'h1);
      load(32'h5f01ffff);
      for (i = 0; i < 8; i++) access({i[2:0], 13'h1abc}, 1'h1);
      op(8'h00);
      chk({19'h0, irq_inhibit}, 20'h1);
      op(8'hea);
      chk({19'h0, irq_inhibit}, 20'h0);
      repeat (12) begin
         load($random(seed));
         op(8'hea);
         repeat (6) begin
            w = $random(seed);
            access(w[15:0], w[16]);
         end
      end
      load(32'hffffffff);
      rst = 1'h1;
      @(negedge clock);
      rst = 1'h0;
      for (i = 0; i < 4; i++) m[i] = 8'h00;
      chk({19'h0, irq_inhibit}, 20'h0);
      access(16'hc3a5, 1'h1);
      end_sim;
   end
endmodule
